// ===== hdl/pin_override_defs.svh
`ifndef PIN_OVERRIDE_DEFS_SVH
`define PIN_OVERRIDE_DEFS_SVH
`define PC_DAC_BIT 7
`define PC_STG2_OUT3_BIT 3
`define PC_STG2_OUT2_BIT 2
`define PC_TMR1_CMPB_BIT 1
`define PC_STG1_OUT0_BIT 0
`define PD_EXT_IRQ0_BIT 6
`define PD_RX_SCK_BIT 4
`define PD_TX_MOSI_BIT 3
`define PORT_RST_VAL 8'h00
`define PORT_BITS 8
`endif

// ===== hdl/pin_override_pkg.sv
package pin_override_pkg;
  typedef logic [7:0] port_byte_t;
endpackage

// ===== hdl/port_c_d_alt_function_override.sv
`timescale 1ns/10ps
`default_nettype none
`include "pin_override_defs.svh"
module port_c_d_alt_function_override
#(
  parameter int PORT_W = `PORT_BITS
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [PORT_W-1:0] i_portc_out,
  input wire logic [PORT_W-1:0] i_portc_dir,
  input wire logic [PORT_W-1:0] i_portd_out,
  input wire logic [PORT_W-1:0] i_portd_dir,
  input wire logic i_pull_up_disable,
  input wire logic [PORT_W-1:0] i_portc_pin,
  input wire logic [PORT_W-1:0] i_portd_pin,
  input wire logic i_converter_output_enable,
  input wire logic i_stage2_out3,
  input wire logic i_stage2_out3_en,
  input wire logic i_stage2_out2,
  input wire logic i_stage2_out2_en,
  input wire logic i_stage1_out0,
  input wire logic i_stage1_out0_en,
  input wire logic i_tmr1_cmp_b_out,
  input wire logic i_tmr1_cmp_b_out_en,
  input wire logic i_tmr0_cmp_a_out,
  input wire logic i_tmr0_cmp_a_out_en,
  input wire logic i_ext_irq3_enable,
  input wire logic i_ext_irq0_enable,
  input wire logic i_rx_enable,
  input wire logic i_tx_enable,
  input wire logic i_tx_data,
  input wire logic i_spi_enable,
  input wire logic i_spi_master,
  input wire logic i_spi_alt_pins,
  input wire logic i_spi_mosi_out,
  output logic [PORT_W-1:0] o_portc_oe,
  output logic [PORT_W-1:0] o_portc_o,
  output logic [PORT_W-1:0] o_portc_pullup,
  output logic [PORT_W-1:0] o_portc_din_en,
  output logic [PORT_W-1:0] o_portd_oe,
  output logic [PORT_W-1:0] o_portd_o,
  output logic [PORT_W-1:0] o_portd_pullup,
  output logic [PORT_W-1:0] o_portd_din_en,
  output logic o_tmr1_ext_count_in,
  output logic o_tmr0_ext_count_in,
  output logic o_stage1_dig_in,
  output logic o_ext_irq3_in,
  output logic o_ext_irq0_in,
  output logic o_tmr1_capture_in,
  output logic o_spi_sck_in,
  output logic o_spi_mosi_in,
  output logic o_spi_slave_sel_n
);

  // plain port behaviour; pull-up only on an input with output bit one
  function automatic pin_override_pkg::port_byte_t plain_pullup(
    input pin_override_pkg::port_byte_t dir,
    input pin_override_pkg::port_byte_t val,
    input logic pud
  );
    plain_pullup = ~dir & val & {8{~pud}};
  endfunction

  wire logic spi_slave_alt;
  wire logic spi_master_alt;
  wire logic pd4_force_in;
  wire logic pd3_force_in;
  wire logic [PORT_W-1:0] portc_oe_next;
  wire logic [PORT_W-1:0] portc_o_next;
  wire logic [PORT_W-1:0] portc_din_en_next;
  wire logic [PORT_W-1:0] portd_oe_next;
  wire logic [PORT_W-1:0] portd_o_next;
  wire logic [PORT_W-1:0] portd_pullup_next;
  wire logic [PORT_W-1:0] portd_plain_pu;
  wire logic pd3_dir;
  wire logic pd3_val;
  wire logic pd3_pu;
  wire logic pd4_dir;
  wire logic pd4_pu;

  assign spi_slave_alt = i_spi_enable & ~i_spi_master & i_spi_alt_pins;
  assign spi_master_alt = i_spi_enable & i_spi_master & i_spi_alt_pins;
  assign pd4_force_in = i_rx_enable | spi_slave_alt;
  // transmitter wins over spi slave: it must own the line while enabled
  assign pd3_force_in = spi_slave_alt & ~i_tx_enable;

  // port c direction
  assign portc_oe_next[7] = i_converter_output_enable ? 1'b0 : i_portc_dir[7];
  assign portc_oe_next[6:4] = i_portc_dir[6:4];
  assign portc_oe_next[3] = i_stage2_out3_en | i_portc_dir[3];
  assign portc_oe_next[2] = i_stage2_out2_en | i_portc_dir[2];
  assign portc_oe_next[1] = i_portc_dir[1];
  assign portc_oe_next[0] = i_stage1_out0_en | i_portc_dir[0];

  // port c value
  assign portc_o_next[7:4] = i_portc_out[7:4];
  assign portc_o_next[3] = i_stage2_out3_en ? i_stage2_out3 : i_portc_out[3];
  assign portc_o_next[2] = i_stage2_out2_en ? i_stage2_out2 : i_portc_out[2];
  // compare b also carries the pwm waveform; timer supplies it on the same line
  assign portc_o_next[1] = i_tmr1_cmp_b_out_en ? i_tmr1_cmp_b_out : i_portc_out[1];
  assign portc_o_next[0] = i_stage1_out0_en ? i_stage1_out0 : i_portc_out[0];

  // port c digital input enable
  assign portc_din_en_next[7] = ~i_converter_output_enable;
  assign portc_din_en_next[6:1] = 6'h3F;
  // irq3 holds the input path on; nothing here turns it off otherwise
  assign portc_din_en_next[0] = i_ext_irq3_enable | 1'b1;

  // port d bit 4
  assign pd4_dir = pd4_force_in ? 1'b0 : i_portd_dir[4];
  assign pd4_pu = ~pd4_dir & i_portd_out[4] & ~i_pull_up_disable;

  // port d bit 3 direction: transmitter, then spi slave, then direction bit; value: transmitter, compare a, spi master, port bit
  assign pd3_dir = i_tx_enable ? 1'b1 : (pd3_force_in ? 1'b0 : i_portd_dir[3]);
  assign pd3_val = i_tx_enable ? i_tx_data :
                   i_tmr0_cmp_a_out_en ? i_tmr0_cmp_a_out :
                   spi_master_alt ? i_spi_mosi_out : i_portd_out[3];
  assign pd3_pu = ~pd3_dir & i_portd_out[3] & ~i_pull_up_disable;

  assign portd_plain_pu = plain_pullup(i_portd_dir, i_portd_out, i_pull_up_disable);
  assign portd_oe_next = {i_portd_dir[7:5], pd4_dir, pd3_dir, i_portd_dir[2:0]};
  assign portd_o_next = {i_portd_out[7:4], pd3_val, i_portd_out[2:0]};
  assign portd_pullup_next = {portd_plain_pu[7:5], pd4_pu, pd3_pu, portd_plain_pu[2:0]};

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_portc_oe <= `PORT_RST_VAL;
      o_portc_o <= `PORT_RST_VAL;
      o_portc_pullup <= `PORT_RST_VAL;
      o_portc_din_en <= `PORT_RST_VAL;
      o_portd_oe <= `PORT_RST_VAL;
      o_portd_o <= `PORT_RST_VAL;
      o_portd_pullup <= `PORT_RST_VAL;
      o_portd_din_en <= `PORT_RST_VAL;
    end
    else
    begin
      o_portc_oe <= portc_oe_next;
      o_portc_o <= portc_o_next;
      // comparator pins take the pull-up from the overridden direction; it drops while a stage output drives them
      o_portc_pullup <= plain_pullup(portc_oe_next, i_portc_out, i_pull_up_disable);
      o_portc_din_en <= portc_din_en_next;
      o_portd_oe <= portd_oe_next;
      o_portd_o <= portd_o_next;
      o_portd_pullup <= portd_pullup_next;
      o_portd_din_en <= {PORT_W{1'b1}};
    end
  end

  // pin inputs are synchronous; one register stage toward peripherals
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tmr1_ext_count_in <= 1'b0;
      o_tmr0_ext_count_in <= 1'b0;
      o_stage1_dig_in <= 1'b0;
      o_ext_irq3_in <= 1'b0;
      o_ext_irq0_in <= 1'b0;
      o_tmr1_capture_in <= 1'b0;
      o_spi_sck_in <= 1'b0;
      o_spi_mosi_in <= 1'b0;
      o_spi_slave_sel_n <= 1'b1;
    end
    else
    begin
      o_tmr1_ext_count_in <= i_portc_pin[`PC_STG2_OUT3_BIT];
      o_tmr0_ext_count_in <= i_portc_pin[`PC_STG2_OUT2_BIT];
      o_stage1_dig_in <= i_portc_pin[`PC_TMR1_CMPB_BIT];
      o_ext_irq3_in <= i_portc_pin[`PC_STG1_OUT0_BIT];
      o_ext_irq0_in <= i_portd_pin[`PD_EXT_IRQ0_BIT];
      o_tmr1_capture_in <= i_portd_pin[`PD_RX_SCK_BIT];
      o_spi_sck_in <= i_portd_pin[`PD_RX_SCK_BIT] & spi_slave_alt;
      o_spi_mosi_in <= i_portd_pin[`PD_TX_MOSI_BIT] & spi_slave_alt;
      // slave deselected unless slave mode on alt pins and pin low
      o_spi_slave_sel_n <= ~spi_slave_alt | i_portd_pin[`PD_TX_MOSI_BIT];
    end
  end

endmodule
`default_nettype wire

// ===== testbench/port_override_props.sv
`timescale 1ns/10ps
`default_nettype none
module port_override_props
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_converter_output_enable,
  input wire logic i_stage2_out3_en,
  input wire logic i_stage2_out3,
  input wire logic i_rx_enable,
  input wire logic i_tx_enable,
  input wire logic i_tx_data,
  input wire logic i_pull_up_disable,
  input wire logic [7:0] i_portc_pin,
  input wire logic [7:0] i_portd_pin,
  input wire logic [7:0] i_portd_out,
  input wire logic [7:0] o_portc_oe,
  input wire logic [7:0] o_portc_o,
  input wire logic [7:0] o_portc_din_en,
  input wire logic [7:0] o_portd_oe,
  input wire logic [7:0] o_portd_o,
  input wire logic [7:0] o_portd_pullup,
  input wire logic o_tmr1_ext_count_in,
  input wire logic o_tmr1_capture_in,
  input wire logic o_ext_irq0_in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence rx_pull_req;
    i_rx_enable && i_portd_out[4] && !i_pull_up_disable;
  endsequence
  AST_PC3_STAGE: assert property (i_stage2_out3_en |=> o_portc_oe[3] &&
    o_portc_o[3] == $past(i_stage2_out3)) else $error("pc3 not stage driven");
  AST_DAC_PIN: assert property (i_converter_output_enable |=>
    !o_portc_oe[7] && !o_portc_din_en[7]) else $error("pc7 not released");
  AST_RX_INPUT: assert property (i_rx_enable |=> !o_portd_oe[4])
    else $error("pd4 driven under rx");
  AST_RX_PULL: assert property (rx_pull_req |=> o_portd_pullup[4])
    else $error("pd4 pull-up off");
  AST_TX_PIN: assert property (i_tx_enable |=> o_portd_oe[3] &&
    o_portd_o[3] == $past(i_tx_data)) else $error("pd3 not tx driven");
  AST_T1_COUNT: assert property (1'h1 |=>
    o_tmr1_ext_count_in == $past(i_portc_pin[3])) else $error("count copy");
  AST_CAPTURE: assert property (1'h1 |=>
    o_tmr1_capture_in == $past(i_portd_pin[4])) else $error("capture copy");
  AST_IRQ0: assert property (1'h1 |=>
    o_ext_irq0_in == $past(i_portd_pin[6])) else $error("irq0 copy");
endmodule
bind port_c_d_alt_function_override port_override_props props_u (.*);
`default_nettype wire

// ===== testbench/periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module periph_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_wave,
  output logic o_pwm
);
  logic [2:0] cnt_reg;
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_reg + 3'h1;
  // both levels show up within eight cycles
  assign o_wave = cnt_reg[0];
  assign o_pwm = (cnt_reg < 3'h3);
endmodule
`default_nettype wire

// ===== testbench/test_port_c_d_alt_function_override.sv
`timescale 1ns/10ps
`default_nettype none
module test_port_c_d_alt_function_override;
  logic i_clk = 1'h0, i_rst = 1'h1, i_stage2_out3, i_tmr1_cmp_b_out, e;
  logic [7:0] i_portc_out = 8'h00, i_portc_dir = 8'h00, i_portd_out = 8'h00;
  logic [7:0] i_portd_dir = 8'h00, i_portc_pin = 8'h00, i_portd_pin = 8'h00;
  logic i_pull_up_disable = 1'h0, i_converter_output_enable = 1'h0, i_stage2_out3_en = 1'h0;
  logic i_stage2_out2 = 1'h0, i_stage2_out2_en = 1'h0, i_stage1_out0 = 1'h0;
  logic i_stage1_out0_en = 1'h0, i_tmr1_cmp_b_out_en = 1'h0, i_tmr0_cmp_a_out = 1'h0;
  logic i_tmr0_cmp_a_out_en = 1'h0, i_ext_irq3_enable = 1'h0, i_ext_irq0_enable = 1'h0;
  logic i_rx_enable = 1'h0, i_tx_enable = 1'h0, i_tx_data = 1'h0, i_spi_enable = 1'h0;
  logic i_spi_master = 1'h0, i_spi_alt_pins = 1'h0, i_spi_mosi_out = 1'h0;
  logic [7:0] o_portc_oe, o_portc_o, o_portc_pullup, o_portc_din_en;
  logic [7:0] o_portd_oe, o_portd_o, o_portd_pullup, o_portd_din_en;
  logic o_tmr1_ext_count_in, o_tmr0_ext_count_in, o_stage1_dig_in, o_ext_irq3_in;
  logic o_ext_irq0_in, o_tmr1_capture_in, o_spi_sck_in, o_spi_mosi_in, o_spi_slave_sel_n;
  int error_cnt = 0, checks = 0;
  port_c_d_alt_function_override dut_u (.*);
  periph_model peri_u (.i_clk, .i_rst, .o_wave(i_stage2_out3), .o_pwm(i_tmr1_cmp_b_out));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_portc;
    @(posedge i_clk);
    {i_portc_out, i_portc_dir, i_portc_pin} <= {8'hA5, 8'h8A, 8'h0B};
    {i_converter_output_enable, i_stage2_out3_en, i_stage2_out2_en} <= 3'h7;
    {i_stage2_out2, i_stage1_out0_en, i_ext_irq3_enable} <= 3'h7;
    tick;
    e = i_stage2_out3;
    tick;
    chk(o_portc_oe, 8'h0F);
    chk(o_portc_o, 8'hA4 | {4'h0, e, 3'h0});
    chk(o_portc_din_en, 8'h7F);
    chk(o_portc_pullup, 8'hA0);
    chk({4'h0, o_tmr1_ext_count_in, o_tmr0_ext_count_in, o_stage1_dig_in, o_ext_irq3_in}, 8'h0B);
    @(posedge i_clk);
    {i_converter_output_enable, i_stage2_out3_en, i_stage2_out2_en, i_stage1_out0_en} <= 4'h0;
    tick;
    chk(o_portc_oe, 8'h8A);
    chk(o_portc_o, 8'hA5);
    chk(o_portc_din_en, 8'hFF);
  endtask
  task automatic t_cmpb;
    @(posedge i_clk);
    {i_tmr1_cmp_b_out_en, i_portc_out, i_portc_dir} <= {1'h1, 8'h02, 8'h00};
    tick;
    chk({7'h00, o_portc_oe[1]}, 8'h00);
    @(posedge i_clk);
    i_portc_dir <= 8'h02;
    tick;
    for (int k = 0; k < 8; k++)
    begin
      e = i_tmr1_cmp_b_out;
      tick;
      chk({6'h00, o_portc_oe[1], o_portc_o[1]}, {7'h01, e});
    end
  endtask
  task automatic t_pd4;
    @(posedge i_clk);
    {i_portd_dir, i_portd_out, i_portd_pin} <= {8'h18, 8'h10, 8'h50};
    i_rx_enable <= 1'h1;
    tick;
    chk(o_portd_oe, 8'h08);
    chk(o_portd_pullup, 8'h10);
    chk({6'h00, o_tmr1_capture_in, o_ext_irq0_in}, 8'h03);
    chk(o_portd_din_en, 8'hFF);
    @(posedge i_clk);
    i_pull_up_disable <= 1'h1;
    tick;
    chk(o_portd_pullup, 8'h00);
    @(posedge i_clk);
    {i_rx_enable, i_pull_up_disable, i_spi_enable, i_spi_alt_pins} <= 4'h3;
    i_portd_pin <= 8'h10;
    tick;
    chk(o_portd_oe, 8'h00);
    chk(o_portd_pullup, 8'h10);
    chk({5'h00, o_spi_sck_in, o_spi_mosi_in, o_spi_slave_sel_n}, 8'h04);
    @(posedge i_clk);
    {i_spi_master, i_spi_mosi_out, i_portd_out} <= {2'h3, 8'h00};
    tick;
    chk(o_portd_oe, 8'h18);
    chk(o_portd_o, 8'h08);
  endtask
  task automatic t_pd3;
    @(posedge i_clk);
    {i_spi_enable, i_spi_master, i_spi_alt_pins, i_portd_dir} <= {3'h0, 8'h00};
    {i_tx_enable, i_tx_data, i_tmr0_cmp_a_out_en, i_tmr0_cmp_a_out} <= 4'hE;
    tick;
    chk({6'h00, o_portd_oe[3], o_portd_o[3]}, 8'h03);
    @(posedge i_clk);
    {i_tx_enable, i_tmr0_cmp_a_out} <= 2'h1;
    tick;
    chk({6'h00, o_portd_oe[3], o_portd_o[3]}, 8'h01);
    @(posedge i_clk);
    i_portd_dir <= 8'h08;
    tick;
    chk({6'h00, o_portd_oe[3], o_portd_o[3]}, 8'h03);
  endtask
  initial
  begin
    tick;
    chk({o_portd_oe[7:1], o_spi_slave_sel_n}, 8'h01);
    repeat (9) @(posedge i_clk);
    i_rst <= 1'h0;
    t_portc;
    t_cmpb;
    t_pd4;
    t_pd3;
    finish_test;
  end
endmodule
`default_nettype wire
